// ==== hw/apc_pkg.sv ====
package apc_pkg;

    // ****************************************************************
    // Register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [7:0] IDX_GREEN_OFFSET_HIGH  = 8'h1A;
    localparam logic [7:0] IDX_GREEN_OFFSET_LOW   = 8'h1B;
    localparam logic [7:0] IDX_BLUE_OFFSET_HIGH   = 8'h1C;
    localparam logic [7:0] IDX_BLUE_OFFSET_LOW    = 8'h1D;
    localparam logic [7:0] IDX_LINE_LENGTH_HIGH   = 8'h1E;
    localparam logic [7:0] IDX_LINE_LENGTH_LOW    = 8'h1F;
    localparam logic [7:0] IDX_SAMPLING_PHASE     = 8'h20;
    localparam logic [7:0] IDX_COAST_BEFORE_VSYNC = 8'h21;
    localparam logic [7:0] IDX_COAST_AFTER_VSYNC  = 8'h22;
    localparam logic [7:0] IDX_PLL_OPTIONS        = 8'h23;
    localparam logic [7:0] IDX_CLAMP_START_HIGH   = 8'h24;
    localparam logic [7:0] IDX_CLAMP_START_LOW    = 8'h25;
    localparam logic [7:0] IDX_CLAMP_WIDTH        = 8'h26;
    localparam logic [7:0] IDX_LOOP_CONTROL       = 8'h30;
    localparam logic [7:0] IDX_LINE_LENGTH_STATUS = 8'h31;

    // ****************************************************************
    // Bus layout
    // ****************************************************************
    localparam int ADDR_WIDTH = 12;
    localparam int IDX_LSB    = 2;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************************************
    // Values after reset
    // ****************************************************************
    localparam logic [7:0] RST_OFFSET_HIGH        = 8'h80;
    localparam logic [7:0] RST_OFFSET_LOW         = 8'h00;
    localparam logic [5:0] RST_LINE_LENGTH_HIGH   = 6'h06;
    localparam logic [7:0] RST_LINE_LENGTH_LOW    = 8'h98;
    localparam logic [5:0] RST_SAMPLING_PHASE     = 6'h00;
    localparam logic [7:0] RST_COAST_BEFORE_VSYNC = 8'h04;
    localparam logic [7:0] RST_COAST_AFTER_VSYNC  = 8'h04;
    localparam logic [4:0] RST_PLL_OPTIONS        = 5'h00;
    localparam logic [5:0] RST_CLAMP_START_HIGH   = 6'h00;
    localparam logic [7:0] RST_CLAMP_START_LOW    = 8'h02;
    localparam logic [7:0] RST_CLAMP_WIDTH        = 8'h10;
    localparam logic       RST_LOOP_ENABLE        = 1'b1;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int OPT_LOCK_EDGE    = 0;
    localparam int OPT_INVERT_EN    = 1;
    localparam int OPT_COAST_SEL    = 2;
    localparam int OPT_COAST_POL    = 3;
    localparam int OPT_EXT_CLOCK    = 4;
    localparam int OFFSET_LOW_MSB   = 7;
    localparam int OFFSET_LOW_LSB   = 6;
    localparam int LOOP_ENABLE_BIT  = 0;

endpackage : apc_pkg

// ==== hw/apc_config_regs.sv ====
// Function
// - 14-bit line length split; low write applies
// - Six-bit sampling phase field
// - Eight-bit coast lines before vsync, default 4
// - Eight-bit coast lines after vsync, default 4
// - Options bit0 selects lock edge
// - Options bit1 gates clock invert input
// - Options bit2 selects external coast source
// - Options bit3 sets external coast polarity
// - Options bit4 selects external pixel clock
// - 14-bit clamp start pixel, default 2
// - Eight-bit clamp width, default 0x10
// - Zero width never connects clamp DAC
// - Green high byte: DAC or digital offset
// - Blue high byte: DAC or digital offset
// - Offset low bits 7:6 give LSBs
// - Loop off: DAC used, adder adds nothing
module apc_config_regs
    import apc_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [apc_pkg::ADDR_WIDTH-1:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [apc_pkg::ADDR_WIDTH-1:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        clock_invert_input,
    input  wire logic        coast_input,
    output logic [13:0]      line_length_pixels,
    output logic [5:0]       sampling_phase,
    output logic [7:0]       coast_before_vsync,
    output logic [7:0]       coast_after_vsync,
    output logic             lock_to_leading_edge,
    output logic             clock_invert_active,
    output logic             coast_from_external,
    output logic             coast_external_active,
    output logic             use_external_pixel_clock,
    output logic [13:0]      clamp_start_pixel,
    output logic [7:0]       clamp_width,
    output logic             clamp_enable,
    output logic [9:0]       green_offset_dac,
    output logic [7:0]       green_digital_offset,
    output logic [9:0]       blue_offset_dac,
    output logic [7:0]       blue_digital_offset,
    output logic             auto_black_level_loop
);
    import apc_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [7:0]  green_high;
        logic [1:0]  green_low;
        logic [7:0]  blue_high;
        logic [1:0]  blue_low;
        logic [5:0]  len_high;
        logic [7:0]  len_low;
        logic [13:0] len_applied;
        logic [5:0]  phase;
        logic [7:0]  coast_pre;
        logic [7:0]  coast_post;
        logic [4:0]  options;
        logic [5:0]  start_high;
        logic [7:0]  start_low;
        logic [7:0]  width;
        logic        loop_en;
        logic [2:0]  inv_sync;
        logic        inv_level;
        logic [2:0]  coast_sync;
        logic        coast_level;
        logic        aw_full;
        logic [7:0]  aw_idx;
        logic        w_full;
        logic [7:0]  w_data;
        logic        w_lane;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        o_inv;
        logic        o_coast;
        logic        o_clamp_en;
        logic [9:0]  o_g_dac;
        logic [7:0]  o_g_dig;
        logic [9:0]  o_b_dac;
        logic [7:0]  o_b_dig;
    } apc_state_t;

    apc_state_t st_reg;
    apc_state_t st_next;

    function automatic logic idx_mapped(input logic [7:0] idx);
        idx_mapped = (idx >= IDX_GREEN_OFFSET_HIGH && idx <= IDX_CLAMP_WIDTH) ||
                     idx == IDX_LOOP_CONTROL || idx == IDX_LINE_LENGTH_STATUS;
    endfunction

    function automatic logic [7:0] read_reg(input apc_state_t s, input logic [7:0] idx);
        case (idx)
            IDX_GREEN_OFFSET_HIGH:  read_reg = s.green_high;
            IDX_GREEN_OFFSET_LOW:   read_reg = {s.green_low, 6'h00};
            IDX_BLUE_OFFSET_HIGH:   read_reg = s.blue_high;
            IDX_BLUE_OFFSET_LOW:    read_reg = {s.blue_low, 6'h00};
            IDX_LINE_LENGTH_HIGH:   read_reg = {2'h0, s.len_high};
            IDX_LINE_LENGTH_LOW:    read_reg = s.len_low;
            IDX_SAMPLING_PHASE:     read_reg = {2'h0, s.phase};
            IDX_COAST_BEFORE_VSYNC: read_reg = s.coast_pre;
            IDX_COAST_AFTER_VSYNC:  read_reg = s.coast_post;
            IDX_PLL_OPTIONS:        read_reg = {3'h0, s.options};
            IDX_CLAMP_START_HIGH:   read_reg = {2'h0, s.start_high};
            IDX_CLAMP_START_LOW:    read_reg = s.start_low;
            IDX_CLAMP_WIDTH:        read_reg = s.width;
            IDX_LOOP_CONTROL:       read_reg = {7'h00, s.loop_en};
            default:                read_reg = 8'h00;
        endcase
    endfunction

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic [7:0] ar_idx;
        logic       do_write;
        ar_idx   = s_axi_araddr[IDX_LSB +: 8];
        do_write = 1'b0;
        st_next  = st_reg;

        // Three-stage pin synchronisers; a level counts once stages two and three agree
        st_next.inv_sync   = {st_reg.inv_sync[1:0], clock_invert_input};
        st_next.coast_sync = {st_reg.coast_sync[1:0], coast_input};
        if (st_reg.inv_sync[1] == st_reg.inv_sync[2]) begin
            st_next.inv_level = st_reg.inv_sync[2];
        end
        if (st_reg.coast_sync[1] == st_reg.coast_sync[2]) begin
            st_next.coast_level = st_reg.coast_sync[2];
        end

        // Write address and data may arrive in either order
        if (s_axi_awvalid && st_reg.awready) begin
            st_next.aw_full = 1'b1;
            st_next.aw_idx  = s_axi_awaddr[IDX_LSB +: 8];
        end
        if (s_axi_wvalid && st_reg.wready) begin
            st_next.w_full = 1'b1;
            st_next.w_data = s_axi_wdata[7:0];
            st_next.w_lane = s_axi_wstrb[0];
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        if (st_next.aw_full && st_next.w_full && !st_next.bvalid) begin
            st_next.aw_full = 1'b0;
            st_next.w_full  = 1'b0;
            st_next.bvalid  = 1'b1;
            st_next.bresp   = idx_mapped(st_next.aw_idx) ? RESP_OKAY : RESP_SLVERR;
            do_write        = st_next.w_lane;
        end

        if (do_write) begin
            case (st_next.aw_idx)
                IDX_GREEN_OFFSET_HIGH:  st_next.green_high = st_next.w_data;
                IDX_GREEN_OFFSET_LOW:   st_next.green_low  = st_next.w_data[OFFSET_LOW_MSB:OFFSET_LOW_LSB];
                IDX_BLUE_OFFSET_HIGH:   st_next.blue_high  = st_next.w_data;
                IDX_BLUE_OFFSET_LOW:    st_next.blue_low   = st_next.w_data[OFFSET_LOW_MSB:OFFSET_LOW_LSB];
                IDX_LINE_LENGTH_HIGH:   st_next.len_high   = st_next.w_data[5:0];
                IDX_LINE_LENGTH_LOW: begin
                    st_next.len_low     = st_next.w_data;
                    // Divider sees both bytes at once, never a half-updated length
                    st_next.len_applied = {st_reg.len_high, st_next.w_data};
                end
                IDX_SAMPLING_PHASE:     st_next.phase      = st_next.w_data[5:0];
                IDX_COAST_BEFORE_VSYNC: st_next.coast_pre  = st_next.w_data;
                IDX_COAST_AFTER_VSYNC:  st_next.coast_post = st_next.w_data;
                IDX_PLL_OPTIONS:        st_next.options    = st_next.w_data[4:0];
                IDX_CLAMP_START_HIGH:   st_next.start_high = st_next.w_data[5:0];
                IDX_CLAMP_START_LOW:    st_next.start_low  = st_next.w_data;
                IDX_CLAMP_WIDTH:        st_next.width      = st_next.w_data;
                IDX_LOOP_CONTROL:       st_next.loop_en    = st_next.w_data[LOOP_ENABLE_BIT];
                default: begin
                end
            endcase
        end

        // Hold off new address and data while a response is still owed
        st_next.awready = !st_next.aw_full && !st_next.bvalid;
        st_next.wready  = !st_next.w_full && !st_next.bvalid;

        // Read channel: one read outstanding, answered on the next edge
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_reg.arready) begin
            st_next.rvalid = 1'b1;
            st_next.rresp  = idx_mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
            if (ar_idx == IDX_LINE_LENGTH_STATUS) begin
                st_next.rdata = {18'h0_0000, st_reg.len_applied};
            end else begin
                st_next.rdata = {24'h00_0000, read_reg(st_reg, ar_idx)};
            end
        end
        st_next.arready = !st_next.rvalid;

        // Derived outputs, registered so every port leaves a flip-flop
        st_next.o_inv      = st_next.options[OPT_INVERT_EN] && st_next.inv_level;
        st_next.o_coast    = st_next.options[OPT_COAST_SEL] &&
                             (st_next.coast_level ^ st_next.options[OPT_COAST_POL]);
        st_next.o_clamp_en = st_next.width != 8'h00;
        if (st_next.loop_en) begin
            // Digital offset path; DAC parked at mid-scale
            st_next.o_g_dac = {RST_OFFSET_HIGH, 2'h0};
            st_next.o_b_dac = {RST_OFFSET_HIGH, 2'h0};
            st_next.o_g_dig = st_next.green_high;
            st_next.o_b_dig = st_next.blue_high;
        end else begin
            st_next.o_g_dac = {st_next.green_high, st_next.green_low};
            st_next.o_b_dac = {st_next.blue_high, st_next.blue_low};
            // Adder adds zero; same register stage either way keeps the delay equal
            st_next.o_g_dig = 8'h00;
            st_next.o_b_dig = 8'h00;
        end

        if (!aresetn) begin
            st_next             = '0;
            st_next.green_high  = RST_OFFSET_HIGH;
            st_next.green_low   = RST_OFFSET_LOW[OFFSET_LOW_MSB:OFFSET_LOW_LSB];
            st_next.blue_high   = RST_OFFSET_HIGH;
            st_next.blue_low    = RST_OFFSET_LOW[OFFSET_LOW_MSB:OFFSET_LOW_LSB];
            st_next.len_high    = RST_LINE_LENGTH_HIGH;
            st_next.len_low     = RST_LINE_LENGTH_LOW;
            st_next.len_applied = {RST_LINE_LENGTH_HIGH, RST_LINE_LENGTH_LOW};
            st_next.phase       = RST_SAMPLING_PHASE;
            st_next.coast_pre   = RST_COAST_BEFORE_VSYNC;
            st_next.coast_post  = RST_COAST_AFTER_VSYNC;
            st_next.options     = RST_PLL_OPTIONS;
            st_next.start_high  = RST_CLAMP_START_HIGH;
            st_next.start_low   = RST_CLAMP_START_LOW;
            st_next.width       = RST_CLAMP_WIDTH;
            st_next.loop_en     = RST_LOOP_ENABLE;
            st_next.bresp       = RESP_OKAY;
            st_next.rresp       = RESP_OKAY;
            st_next.o_clamp_en  = 1'b1;
            st_next.o_g_dac     = {RST_OFFSET_HIGH, 2'h0};
            st_next.o_b_dac     = {RST_OFFSET_HIGH, 2'h0};
            st_next.o_g_dig     = RST_OFFSET_HIGH;
            st_next.o_b_dig     = RST_OFFSET_HIGH;
        end
    end

    always_ff @(posedge aclk) begin
        st_reg <= st_next;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign s_axi_awready            = st_reg.awready;
    assign s_axi_wready             = st_reg.wready;
    assign s_axi_bvalid             = st_reg.bvalid;
    assign s_axi_bresp              = st_reg.bresp;
    assign s_axi_arready            = st_reg.arready;
    assign s_axi_rvalid             = st_reg.rvalid;
    assign s_axi_rdata              = st_reg.rdata;
    assign s_axi_rresp              = st_reg.rresp;
    assign line_length_pixels       = st_reg.len_applied;
    assign sampling_phase           = st_reg.phase;
    assign coast_before_vsync       = st_reg.coast_pre;
    assign coast_after_vsync        = st_reg.coast_post;
    assign lock_to_leading_edge     = st_reg.options[OPT_LOCK_EDGE];
    assign clock_invert_active      = st_reg.o_inv;
    assign coast_from_external      = st_reg.options[OPT_COAST_SEL];
    assign coast_external_active    = st_reg.o_coast;
    assign use_external_pixel_clock = st_reg.options[OPT_EXT_CLOCK];
    assign clamp_start_pixel        = {st_reg.start_high, st_reg.start_low};
    assign clamp_width              = st_reg.width;
    assign clamp_enable             = st_reg.o_clamp_en;
    assign green_offset_dac         = st_reg.o_g_dac;
    assign green_digital_offset     = st_reg.o_g_dig;
    assign blue_offset_dac          = st_reg.o_b_dac;
    assign blue_digital_offset      = st_reg.o_b_dig;
    assign auto_black_level_loop    = st_reg.loop_en;

endmodule // apc_config_regs

// ==== verif/apc_config_regs_props.sv ====
module apc_regs_chk
    import apc_pkg::*;
(
    input wire logic                  aclk,
    input wire logic                  aresetn,
    input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic                  s_axi_awvalid,
    input wire logic                  s_axi_awready,
    input wire logic                  s_axi_wvalid,
    input wire logic                  s_axi_wready,
    input wire logic                  s_axi_bvalid,
    input wire logic                  s_axi_arvalid,
    input wire logic                  s_axi_arready,
    input wire logic [31:0]           s_axi_rdata,
    input wire logic [1:0]            s_axi_rresp,
    input wire logic                  s_axi_rvalid,
    input wire logic [13:0]           line_length_pixels,
    input wire logic                  coast_from_external,
    input wire logic                  coast_external_active,
    input wire logic [7:0]            clamp_width,
    input wire logic                  clamp_enable,
    input wire logic [9:0]            green_offset_dac,
    input wire logic [9:0]            blue_offset_dac,
    input wire logic [7:0]            green_digital_offset,
    input wire logic [7:0]            blue_digital_offset,
    input wire logic                  auto_black_level_loop
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Write address tracker
    // ****************************************
    // AW may be taken cycles before the write lands, so remember its index
    logic [7:0] aw_idx_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) aw_idx_reg <= 8'h00;
        else if (s_axi_awvalid && s_axi_awready) aw_idx_reg <= s_axi_awaddr[9:2];
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ****************************************
    // Properties
    // ****************************************
    chk_clamp_gate: assert property (clamp_enable == (clamp_width != 8'h00))
        else $error("clamp enable disagrees with clamp width");
    chk_dac_parked: assert property (auto_black_level_loop |->
        green_offset_dac == 10'h200 && blue_offset_dac == 10'h200)
        else $error("offset dac not parked while loop on");
    chk_adder_idle: assert property (!auto_black_level_loop |->
        green_digital_offset == 8'h00 && blue_digital_offset == 8'h00)
        else $error("digital offset nonzero while loop off");
    chk_len_on_low: assert property ($changed(line_length_pixels) |->
        $rose(s_axi_bvalid) && aw_idx_reg == IDX_LINE_LENGTH_LOW)
        else $error("line length changed without low byte write");
    chk_coast_source: assert property (coast_external_active |-> coast_from_external)
        else $error("external coast active while source internal");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
        else $error("write response missing one cycle after address and data");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data missing one cycle after address");
    chk_err_rdata: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000)
        else $error("error read returned nonzero data");
    chk_quiet_after_b: assert property ($fell(s_axi_bvalid) |-> s_axi_awready && s_axi_wready)
        else $error("write address ready not back after response");
endmodule // apc_regs_chk

bind apc_config_regs apc_regs_chk u_chk (.*);

// ==== verif/apc_config_regs_bench.sv ====
module apc_config_regs_bench
    import apc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, inv_pin, coast_pin;
    logic        lock, inv_act, c_ext, c_act, ext_clk, c_en, loop;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [13:0] len, cstart;
    logic [5:0]  phase;
    logic [7:0]  cb, ca, cw, gdig, bdig;
    logic [9:0]  gdac, bdac;
    logic [15:0] r;
    logic [1:0]  exp_b [$];
    logic [33:0] exp_r [$];
    int          miscompares = 0;
    int          tests_run = 0;
    int          cyc = 0;
    logic [7:0]  ridx [15] = '{8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24,
                               8'h25, 8'h26, 8'h30, 8'h31};
    logic [31:0] rexp [15] = '{32'h80, 32'h0, 32'h80, 32'h0, 32'h06, 32'h98, 32'h0, 32'h04, 32'h04, 32'h0,
                               32'h0, 32'h02, 32'h10, 32'h01, 32'h0698};
    logic [7:0]  oval [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h0C};
    logic [7:0]  oexp [6] = '{8'h01, 8'h02, 8'h04, 8'h00, 8'h10, 8'h0C};

    apc_config_regs dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .clock_invert_input(inv_pin),
        .coast_input(coast_pin), .line_length_pixels(len), .sampling_phase(phase), .coast_before_vsync(cb),
        .coast_after_vsync(ca), .lock_to_leading_edge(lock), .clock_invert_active(inv_act),
        .coast_from_external(c_ext), .coast_external_active(c_act), .use_external_pixel_clock(ext_clk),
        .clamp_start_pixel(cstart), .clamp_width(cw), .clamp_enable(c_en), .green_offset_dac(gdac),
        .green_digital_offset(gdig), .blue_offset_dac(bdac), .blue_digital_offset(bdig),
        .auto_black_level_loop(loop));

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
        int n;
        exp_b.push_back(er);
        @(posedge aclk);
        {awaddr, wdata, wstrb} <= {2'b00, idx, 2'b00, d ^ 8'hA5, 16'h0000, d, s};
        {awvalid, wvalid, bready} <= 3'b111;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (n == 50) miscompares++;
    endtask

    task automatic wrok(input logic [7:0] idx, input logic [7:0] d);
        wr(idx, d, 4'hF, RESP_OKAY);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] ed, input logic [1:0] er);
        int n;
        exp_r.push_back({er, ed});
        @(posedge aclk);
        araddr <= {2'b00, idx, 2'b00};
        {arvalid, rready} <= 2'b11;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        if (n == 50) miscompares++;
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // ****************************************
    // Clock, monitor and timeout
    // ****************************************
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            summarize();
        end
        if (aresetn && bvalid && bready) begin
            if (exp_b.size() == 0) miscompares++;
            else chk("bresp", {30'h0, bresp}, {30'h0, exp_b.pop_front()});
        end
        if (aresetn && rvalid && rready) begin
            if (exp_r.size() == 0) miscompares++;
            else chk("read", {rresp, rdata}, exp_r.pop_front());
        end
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, coast_pin} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        inv_pin = 1'b1;
        r = 16'd13616;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk("line_length", {18'h0, len}, 32'h0698);
        chk("clamp_start", {18'h0, cstart}, 32'h0002);
        chk("clamp_enable", {31'h0, c_en}, 32'h1);
        for (int i = 0; i < 15; i++) rd(ridx[i], rexp[i], RESP_OKAY);
        $display("reset values done");
        wrok(IDX_LINE_LENGTH_HIGH, 8'hFF);
        @(negedge aclk);
        chk("line_length", {18'h0, len}, 32'h0698);
        rd(IDX_LINE_LENGTH_HIGH, 32'h3F, RESP_OKAY);
        wrok(IDX_LINE_LENGTH_LOW, 8'hA5);
        @(negedge aclk);
        chk("line_length", {18'h0, len}, 32'h3FA5);
        wrok(IDX_LINE_LENGTH_HIGH, 8'h01);
        wrok(IDX_LINE_LENGTH_HIGH, 8'h02);
        wrok(IDX_LINE_LENGTH_LOW, 8'h00);
        rd(IDX_LINE_LENGTH_STATUS, 32'h0200, RESP_OKAY);
        $display("line length done");
        for (int i = 0; i < 6; i++) begin
            wrok(IDX_PLL_OPTIONS, oval[i]);
            @(negedge aclk);
            chk("options", {27'h0, ext_clk, c_act, c_ext, inv_act, lock}, {24'h0, oexp[i]});
        end
        @(posedge aclk);
        coast_pin <= 1'b1;
        inv_pin <= 1'b0;
        repeat (6) @(posedge aclk);
        wrok(IDX_PLL_OPTIONS, 8'h0E);
        @(negedge aclk);
        chk("options", {27'h0, ext_clk, c_act, c_ext, inv_act, lock}, 32'h04);
        $display("pll options done");
        for (int i = 0; i < 4; i++) begin
            r = lfsr(r);
            wrok(IDX_SAMPLING_PHASE, r[7:0]);
            wrok(IDX_COAST_BEFORE_VSYNC, r[15:8]);
            wrok(IDX_COAST_AFTER_VSYNC, r[7:0] ^ r[15:8]);
            wrok(IDX_CLAMP_START_HIGH, r[15:8]);
            wrok(IDX_CLAMP_START_LOW, r[7:0]);
            wrok(IDX_CLAMP_WIDTH, r[15:8] | 8'h01);
            @(negedge aclk);
            chk("phase", {26'h0, phase}, {26'h0, r[5:0]});
            chk("coast_before", {24'h0, cb}, {24'h0, r[15:8]});
            chk("coast_after", {24'h0, ca}, {24'h0, r[7:0] ^ r[15:8]});
            chk("clamp_start", {18'h0, cstart}, {18'h0, r[13:8], r[7:0]});
            chk("clamp_width", {24'h0, cw}, {24'h0, r[15:8] | 8'h01});
            rd(IDX_SAMPLING_PHASE, {26'h0, r[5:0]}, RESP_OKAY);
        end
        wrok(IDX_CLAMP_WIDTH, 8'h00);
        @(negedge aclk);
        chk("clamp_enable", {31'h0, c_en}, 32'h0);
        $display("timing fields done");
        wrok(IDX_GREEN_OFFSET_HIGH, 8'h5A);
        wrok(IDX_GREEN_OFFSET_LOW, 8'hFF);
        wrok(IDX_BLUE_OFFSET_HIGH, 8'h33);
        wrok(IDX_BLUE_OFFSET_LOW, 8'h40);
        @(negedge aclk);
        chk("digital", {16'h0, gdig, bdig}, 32'h5A33);
        rd(IDX_GREEN_OFFSET_LOW, 32'hC0, RESP_OKAY);
        wrok(IDX_LOOP_CONTROL, 8'h00);
        @(negedge aclk);
        chk("dac", {12'h0, gdac, bdac}, {12'h0, 10'h16B, 10'h0CD});
        chk("digital", {16'h0, gdig, bdig}, 32'h0000);
        chk("loop", {31'h0, loop}, 32'h0);
        $display("offsets done");
        wr(8'h40, 8'h55, 4'hF, RESP_SLVERR);
        rd(8'h40, 32'h0, RESP_SLVERR);
        wr(IDX_SAMPLING_PHASE, 8'h3F, 4'h0, RESP_OKAY);
        rd(IDX_SAMPLING_PHASE, {26'h0, r[5:0]}, RESP_OKAY);
        wr(IDX_LINE_LENGTH_STATUS, 8'h00, 4'hF, RESP_OKAY);
        rd(IDX_LINE_LENGTH_STATUS, 32'h0200, RESP_OKAY);
        repeat (4) @(posedge aclk);
        $display("refusals done");
        summarize();
    end
endmodule // apc_config_regs_bench
